// file: rtl/ssp_cfg.svh
// register offsets, field positions, reset values and bits per exchange of the serial port
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH
// register indices (printed offsets are not multiples of four)
`define SSP_IDX_CTRL 8'hC3
`define SSP_IDX_STAT 8'hC4
`define SSP_IDX_DATA 8'hC5
`define SSP_IDX_IRQ_STAT 8'hC6
`define SSP_IDX_IRQ_MASK 8'hC7
// control field positions
`define SSP_CTL_RATE_HI 7
`define SSP_CTL_ENABLE 6
`define SSP_CTL_SELECT_INPUT_DISABLE 5
`define SSP_CTL_MASTER 4
`define SSP_CTL_CLOCK_POLARITY_BIT 3
`define SSP_CTL_CLOCK_PHASE_BIT 2
`define SSP_CTL_RATE_MID 1
`define SSP_CTL_RATE_LO 0
// status field positions
`define SSP_ST_DONE 7
`define SSP_ST_WRITE_COLLISION_FLAG 6
`define SSP_ST_SLAVE_SELECT_EARLY_FLAG 5
`define SSP_ST_MODE_FAULT_FLAG 4
// interrupt status positions
`define SSP_IRQ_DONE 0
`define SSP_IRQ_MODE_FAULT_FLAG 1
// reset values
`define SSP_CTRL_RST 8'h14
`define SSP_MASK_RST 8'h00
// bus answer to an unmapped index
`define SSP_UNMAPPED 32'h0000_0000
// bits per exchange
`define SSP_BITS 4'h8
`endif

// file: rtl/ssp_core.sv
// serial port status flags, data path, avalon slave and interrupt logic
//
// Summary of operation
// [R1] status bit 7 sets when byte done
// [R2] done flag zero during exchange, cleared by sequence
// [R3] status bit 6 flags a write collision
// [R4] slave: select released early sets bit 5
// [R5] bit 5 cleared only by disabling the port
// [R6] bit 4 flags select level wrong for role
// [R7] mode fault zero when select fine or cleared
// [R8] bits 3..0 reserved, software writes no ones
// [R9] reset clears done, collision, fault flags
// [R10] data write loads shift register directly
// [R11] data read returns receive buffer only
// [R12] no rate change during an exchange
// [R13] no phase, polarity, role change mid-exchange
// [R14] disabling mid-byte stops at once
// [R15] data write mid-exchange is ignored
// [R16] mid-exchange write: collision, no irq, continue
// [R17] collision cleared by status then data access
// [R18] fault cleared by status read then control write
// [R19] irq on done; fault irq only if select enabled
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ssp_cfg.svh"

module ssp_core #(
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire ssp_pkg::ssp_pins_t pins_in,
   output ssp_pkg::ssp_drive_t pins_out,
   output logic irq
);
   import ssp_pkg::*;

   // ===========================================================
   // pin synchronisers
   // ===========================================================
   ssp_pins_t sync1_q;
   ssp_pins_t sync2_q;
   logic sck_prev_q;
   // two stages before anything reads a pin; reset to the idle line levels
   // so the edge finder sees no false clock edge right after reset
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_q <= '{sck: 1'b0, mosi: 1'b1, miso: 1'b1, ss_n: 1'b1};
         sync2_q <= '{sck: 1'b0, mosi: 1'b1, miso: 1'b1, ss_n: 1'b1};
         sck_prev_q <= 1'b0;
      end else begin
         sync1_q <= pins_in;
         sync2_q <= sync1_q;
         sck_prev_q <= sync2_q.sck;
      end
   end

   // ===========================================================
   // bus slave
   // ===========================================================
   logic ack_q;
   logic [7:0] ctrl_q;
   logic [7:0] mask_q;
   logic [1:0] irq_st_q;
   logic done_q, write_collision_flag_q, slave_select_early_flag_q, mode_fault_flag_q;
   logic [7:0] shift_q;
   logic [7:0] rxbuf_q;
   ssp_state_t state_q;
   logic [3:0] bitcnt_q;
   logic stat_seen_q, mode_fault_flag_seen_q;

   // one wait state per access, answer on the second edge
   wire logic req = (avs_read | avs_write) & ~ack_q;
   wire logic acc = (avs_read | avs_write) & ack_q;
   wire logic lane0 = avs_byteenable[0];
   wire logic wr = acc & avs_write & lane0;
   wire logic rd = acc & avs_read;
   wire logic hit_ctrl = avs_address == ADDR_W'(`SSP_IDX_CTRL);
   wire logic hit_stat = avs_address == ADDR_W'(`SSP_IDX_STAT);
   wire logic hit_data = avs_address == ADDR_W'(`SSP_IDX_DATA);
   wire logic hit_ist = avs_address == ADDR_W'(`SSP_IDX_IRQ_STAT);
   wire logic hit_msk = avs_address == ADDR_W'(`SSP_IDX_IRQ_MASK);
   wire logic enable = ctrl_q[`SSP_CTL_ENABLE];
   wire logic master = ctrl_q[`SSP_CTL_MASTER];
   wire logic select_input_disable = ctrl_q[`SSP_CTL_SELECT_INPUT_DISABLE];
   wire logic clock_polarity_bit = ctrl_q[`SSP_CTL_CLOCK_POLARITY_BIT];
   wire logic clock_phase_bit = ctrl_q[`SSP_CTL_CLOCK_PHASE_BIT];
   wire logic busy = state_q == SSP_SHIFT;

   always_ff @(posedge clk) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req;
      end
   end
   assign avs_waitrequest = ~ack_q;

   // read mux, registered at the request edge
   always_ff @(posedge clk) begin
      if (rst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (req & avs_read) begin
         if (hit_ctrl) begin
            avs_readdata <= {24'h00_0000, ctrl_q};
         end else if (hit_stat) begin
            // reserved low bits read as zero [R8]
            avs_readdata <= {24'h00_0000, done_q, write_collision_flag_q, slave_select_early_flag_q, mode_fault_flag_q, 4'h0};
         end else if (hit_data) begin
            avs_readdata <= {24'h00_0000, rxbuf_q}; // [R11]
         end else if (hit_ist) begin
            avs_readdata <= {30'h0000_0000, irq_st_q};
         end else if (hit_msk) begin
            avs_readdata <= {24'h00_0000, mask_q};
         end else begin
            avs_readdata <= `SSP_UNMAPPED;
         end
      end
   end

   // control register; software keeps rate, phase, polarity, role steady mid-exchange
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q <= `SSP_CTRL_RST;
      end else if (wr & hit_ctrl) begin
         ctrl_q <= avs_writedata[7:0]; // [R12] [R13]
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mask_q <= `SSP_MASK_RST;
      end else if (wr & hit_msk) begin
         mask_q <= avs_writedata[7:0];
      end
   end

   // ===========================================================
   // clock divider and link edges
   // ===========================================================
   logic [6:0] div_q;
   logic sck_q;
   wire logic [2:0] rate = {ctrl_q[`SSP_CTL_RATE_HI], ctrl_q[`SSP_CTL_RATE_MID],
                            ctrl_q[`SSP_CTL_RATE_LO]};
   // half period of the master clock, in clk cycles; code 7 is invalid, treated as slowest
   function automatic logic [6:0] half_period(input logic [2:0] r);
      half_period = (r == 3'h7) ? 7'h40 : 7'(7'h01 << r);
   endfunction
   wire logic tick = busy & master & (div_q == half_period(rate) - 7'h01);
   always_ff @(posedge clk) begin
      if (rst || !busy) begin
         div_q <= 7'h00;
      end else begin
         div_q <= tick ? 7'h00 : div_q + 7'h01;
      end
   end

   wire logic sck_rise = sync2_q.sck & ~sck_prev_q;
   wire logic sck_fall = ~sync2_q.sck & sck_prev_q;
   wire logic ss_act = ~sync2_q.ss_n;
   // slave: leading edge leaves idle level; master: own toggles
   wire logic lead_s = clock_polarity_bit ? sck_fall : sck_rise;
   wire logic trail_s = clock_polarity_bit ? sck_rise : sck_fall;
   wire logic lead_m = tick & (sck_q == clock_polarity_bit);
   wire logic trail_m = tick & (sck_q != clock_polarity_bit);
   wire logic lead = master ? lead_m : (lead_s & ss_act);
   wire logic trail = master ? trail_m : (trail_s & ss_act);
   // clock_phase_bit clear samples on the leading edge, set on the trailing edge
   wire logic sample = clock_phase_bit ? trail : lead;
   wire logic shift_out = clock_phase_bit ? lead : trail;
   wire logic rx_bit = master ? sync2_q.miso : sync2_q.mosi;
   wire logic last = bitcnt_q == (`SSP_BITS - 4'h1);
   wire logic data_wr = wr & hit_data;
   wire logic abort = ~enable; // [R14]
   // slave with phase zero needs select; select release mid-byte is an error
   logic sample_seen_q;
   wire logic ss_early = ~master & busy & sync2_q.ss_n & (bitcnt_q != 4'h0 | sample_seen_q);
   logic finish;

   // ===========================================================
   // transfer state machine
   // ===========================================================
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= SSP_IDLE;
         bitcnt_q <= 4'h0;
         sample_seen_q <= 1'b0;
      end else if (abort) begin
         state_q <= SSP_IDLE; // [R14]
         bitcnt_q <= 4'h0;
         sample_seen_q <= 1'b0;
      end else begin
         case (state_q)
            SSP_IDLE: begin
               bitcnt_q <= 4'h0;
               sample_seen_q <= 1'b0;
               // master starts on a data write; slave on select low
               if ((master & data_wr) | (~master & ss_act)) begin
                  state_q <= SSP_SHIFT;
               end
            end
            SSP_SHIFT: begin
               if (ss_early) begin
                  state_q <= SSP_IDLE;
               end else if (sample) begin
                  sample_seen_q <= 1'b1;
                  if (last) begin
                     state_q <= SSP_DONE;
                  end
               end else if (shift_out) begin
                  bitcnt_q <= bitcnt_q + 4'h1;
                  sample_seen_q <= 1'b0;
               end
            end
            SSP_DONE: begin
               // slave waits for select release before the next byte
               if (master | sync2_q.ss_n) begin
                  state_q <= SSP_IDLE;
               end
            end
            default: state_q <= SSP_IDLE;
         endcase
      end
   end
   assign finish = busy & sample & last & ~ss_early & ~abort;

   // ===========================================================
   // shift register and receive buffer
   // ===========================================================
   always_ff @(posedge clk) begin
      if (rst) begin
         shift_q <= 8'h00;
         rxbuf_q <= 8'h00;
         sck_q <= 1'b0;
      end else begin
         if (data_wr & ~busy) begin
            shift_q <= avs_writedata[7:0]; // [R10]
         end else if (busy & sample) begin
            // mid-exchange data writes are ignored, the byte goes on [R15] [R16]
            shift_q <= {shift_q[6:0], rx_bit};
         end
         if (finish) begin
            rxbuf_q <= {shift_q[6:0], rx_bit}; // [R11]
         end
         sck_q <= (busy & master) ? (tick ? ~sck_q : sck_q) : clock_polarity_bit;
      end
   end

   // outgoing bit, moved only on the shifting edge: the shift register
   // moves on the sampling edge, and driving it straight out would change
   // the data line together with the clock edge that the peer samples on
   logic tx_bit_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_bit_q <= 1'b0;
      end else if (data_wr & ~busy) begin
         tx_bit_q <= avs_writedata[7]; // [R10]
      end else if (~busy | shift_out) begin
         // idle it shows the first bit of the loaded byte
         tx_bit_q <= shift_q[7];
      end
   end

   // pins driven from flops; master owns clock and mosi, slave owns miso while selected
   always_ff @(posedge clk) begin
      if (rst) begin
         pins_out <= '0;
      end else begin
         pins_out.sck <= sck_q;
         pins_out.sck_oe <= enable & master;
         pins_out.mosi <= tx_bit_q;
         pins_out.mosi_oe <= enable & master;
         pins_out.miso <= tx_bit_q;
         pins_out.miso_oe <= enable & ~master & ss_act;
      end
   end

   // ===========================================================
   // status flags
   // ===========================================================
   wire logic mode_fault_flag_cond = enable & ~select_input_disable & (master ? ss_act : 1'b0);
   wire logic collide = data_wr & busy;
   // clearing sequences: status access arms (a read, for the fault), then data access or control write clears
   always_ff @(posedge clk) begin
      if (rst) begin
         stat_seen_q <= 1'b0;
         mode_fault_flag_seen_q <= 1'b0;
      end else if (acc) begin
         stat_seen_q <= hit_stat ? 1'b1 : (hit_data ? 1'b0 : stat_seen_q);
         mode_fault_flag_seen_q <= (rd & hit_stat) ? mode_fault_flag_q : ((wr & hit_ctrl) ? 1'b0 : mode_fault_flag_seen_q);
      end
   end

   // set wins over clear on every flag except bit 5, where disabling wins
   always_ff @(posedge clk) begin
      if (rst) begin
         done_q <= 1'b0; // [R9]
         write_collision_flag_q <= 1'b0;
         mode_fault_flag_q <= 1'b0;
         slave_select_early_flag_q <= 1'b0;
      end else begin
         if (finish) begin
            done_q <= 1'b1; // [R1]
         end else if (busy | (acc & hit_data & stat_seen_q)) begin
            done_q <= 1'b0; // [R2]
         end
         if (collide) begin
            write_collision_flag_q <= 1'b1; // [R3] [R16]
         end else if (acc & hit_data & stat_seen_q) begin
            write_collision_flag_q <= 1'b0; // [R17]
         end
         if (mode_fault_flag_cond) begin
            mode_fault_flag_q <= 1'b1; // [R6]
         end else if (wr & hit_ctrl & mode_fault_flag_seen_q) begin
            mode_fault_flag_q <= 1'b0; // [R7] [R18]
         end
         if (ss_early & ~abort) begin
            slave_select_early_flag_q <= 1'b1; // [R4]
         end else if (abort) begin
            slave_select_early_flag_q <= 1'b0; // [R5]
         end
      end
   end

   // ===========================================================
   // interrupts: sticky, write one to clear, masked onto irq
   // ===========================================================
   wire logic [1:0] ev = {mode_fault_flag_cond & ~mode_fault_flag_q & ~select_input_disable, finish}; // [R19]
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_st_q <= 2'b00;
         irq <= 1'b0;
      end else begin
         irq_st_q <= ev | (irq_st_q & ~((wr & hit_ist) ? avs_writedata[1:0] : 2'b00));
         irq <= |(irq_st_q & mask_q[1:0]); // collision never reaches here [R16]
      end
   end
endmodule
`default_nettype wire

// file: rtl/ssp_pkg.sv
// types shared by the serial port design
package ssp_pkg;
   typedef struct packed {
      logic sck;
      logic mosi;
      logic miso;
      logic ss_n;
   } ssp_pins_t;
   typedef struct packed {
      logic sck;
      logic sck_oe;
      logic mosi;
      logic mosi_oe;
      logic miso;
      logic miso_oe;
   } ssp_drive_t;
   typedef enum logic [1:0] {
      SSP_IDLE,
      SSP_SHIFT,
      SSP_DONE
   } ssp_state_t;
endpackage

// file: verification/ssp_core_props.sv
// bus, reset, interrupt and pin checks of the serial port core
`timescale 1ns/1ps
`default_nettype none
`include "ssp_cfg.svh"
module ssp_core_props #(
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire ssp_pkg::ssp_pins_t pins_in,
   input wire ssp_pkg::ssp_drive_t pins_out,
   input wire logic irq
);
   import ssp_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // answer cycles of the register bus, split by kind
   logic rd_ans;
   logic wr_ans;
   assign rd_ans = avs_read && !avs_waitrequest;
   assign wr_ans = avs_write && !avs_waitrequest && avs_byteenable[0];
   // =========
   // handshake
   a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered after one wait state");
   a_wait_idle: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
      else $error("answer seen with no request");
   a_read_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
      else $error("read data moved without a read");
   // =========
   // status and reset
   a_resv_zero: assert property (rd_ans && avs_address == `SSP_IDX_STAT |-> avs_readdata[3:0] == 4'h0)
      else $error("reserved status bits not zero");
   a_reset_quiet: assert property (@(posedge clk) disable iff (1'b0) rst |=> !irq && avs_waitrequest)
      else $error("outputs not quiet after reset");
   // the core never drives both the clock and the slave output at once
   a_role_excl: assert property (!(pins_out.sck_oe && pins_out.miso_oe))
      else $error("master and slave drivers both on");
   a_sck_quiet: assert property (wr_ans && avs_address == `SSP_IDX_CTRL
      && !avs_writedata[`SSP_CTL_ENABLE] |-> ##4 $stable(pins_out.sck) [*8])
      else $error("clock still moving after disable");
   // =========
   // interrupt line, registered two cycles behind its sources
   a_irq_masked: assert property (wr_ans && avs_address == `SSP_IDX_IRQ_MASK
      && avs_writedata[7:0] == 8'h00 |=> ##1 !irq)
      else $error("irq high with all sources masked");
   a_irq_clear: assert property (wr_ans && avs_address == `SSP_IDX_IRQ_STAT
      && avs_writedata[1:0] == 2'b11 |=> ##1 !irq)
      else $error("irq high after clearing all events");
   c_data_write: cover property (wr_ans && avs_address == `SSP_IDX_DATA);
   c_done_seen: cover property (rd_ans && avs_address == `SSP_IDX_STAT && avs_readdata[7]);
   c_irq_rise: cover property ($rose(irq));
endmodule
bind ssp_core ssp_core_props #(.ADDR_W(ADDR_W)) ssp_core_props_inst (.clk(clk), .rst(rst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pins_in(pins_in),
   .pins_out(pins_out), .irq(irq));
`default_nettype wire

// file: verification/ssp_peer.sv
// serial peer: slave to the core as master, master to the core as slave
`timescale 1ns/1ps
`default_nettype none
module ssp_peer (
   input wire ssp_pkg::ssp_drive_t drv,
   output var ssp_pkg::ssp_pins_t pins
);
   import ssp_pkg::*;
   logic [7:0] tx_q = 8'h00;
   logic [7:0] rx_q = 8'h00;
   logic sck_m = 1'b0;
   logic mosi_m = 1'b0;
   logic ss_n_m = 1'b1;
   // wire levels; an undriven line shows our own drive, miso the inverse of our bit when the core is slave
   assign pins.sck = drv.sck_oe ? drv.sck : sck_m;
   assign pins.mosi = drv.mosi_oe ? drv.mosi : mosi_m;
   assign pins.miso = drv.miso_oe ? drv.miso : (drv.sck_oe ? tx_q[7] : ~tx_q[7]);
   assign pins.ss_n = ss_n_m;
   // mode 0: sample on rising clock, next bit out on falling clock
   always @(posedge pins.sck) rx_q <= {rx_q[6:0], drv.sck_oe ? pins.mosi : pins.miso};
   always @(negedge pins.sck) if (drv.sck_oe) tx_q <= {tx_q[6:0], 1'b0};
   task automatic load(input logic [7:0] b);
      tx_q = b;
   endtask
   task automatic sel(input logic v);
      ss_n_m <= v;
   endtask
   // frame of n bits, msb first, 125 ns clock; clock stands still outside
   task automatic send(input logic [7:0] b, input int n);
      ss_n_m <= 1'b0;
      #62.5;
      for (int i = 7; i > 7 - n; i--) begin
         mosi_m = b[i];
         #62.5 sck_m = 1'b1;
         #62.5 sck_m = 1'b0;
      end
      #62.5 ss_n_m = 1'b1; // early release when n is short
      mosi_m = ~mosi_m;
   endtask
endmodule
`default_nettype wire

// file: verification/testbench.sv
// self-checking bench of the serial port core
`timescale 1ns/1ps
`default_nettype none
`include "ssp_cfg.svh"
module testbench;
   import ssp_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h0000_0000;
   logic [3:0] be = 4'hf;
   logic [31:0] rdd;
   logic [31:0] q;
   logic wt;
   logic irq;
   ssp_pins_t pins;
   ssp_drive_t drv;
   int n_mismatch = 0;
   int n_compared = 0;
   int n;
   // rows: write flag nibble, index, write data, expected read
   logic [27:0] rows [0:7] = '{28'h0C3_0014, 28'h0C4_0000, 28'h0C6_0000, 28'h0C7_0000,
      28'h1C7_0300, 28'h0C7_0003, 28'h110_FF00, 28'h010_0000};
   always #4 clk = ~clk;
   // byte lane 0 normally enabled; one write with it off must be ignored
   ssp_core ssp_core_inst (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdd),
      .avs_waitrequest(wt), .pins_in(pins), .pins_out(drv), .irq(irq));
   ssp_peer ssp_peer_inst (.drv(drv), .pins(pins));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one bus cycle, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      adr <= a;
      wr <= w;
      rd <= !w;
      wd <= {24'h00_0000, d};
      @(posedge clk);
      for (n = 0; n < 50 && wt !== 1'b0; n++) @(posedge clk);
      if (n == 50) n_mismatch++;
      q = rdd;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(q, {24'h00_0000, e});
   endtask
   task automatic end_sim();
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // watchdog, far beyond the few microseconds the tests need
   initial begin
      #200000;
      n_mismatch++;
      end_sim();
   end
   // =========
   // main sequence
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         bus(rows[i][24], rows[i][23:16], rows[i][15:8]);
         if (!rows[i][24]) chk(q, {24'h00_0000, rows[i][7:0]});
      end
      // write with lane 0 off leaves control at its reset value
      be <= 4'he;
      bus(1'b1, `SSP_IDX_CTRL, 8'h00);
      be <= 4'hf;
      rdc(`SSP_IDX_CTRL, 8'h14);
      // master byte with a colliding second write; rate set while idle
      // half period of 8 cycles leaves room for the pin synchroniser latency
      ssp_peer_inst.load(8'ha5);
      bus(1'b1, `SSP_IDX_CTRL, 8'h53);
      bus(1'b1, `SSP_IDX_DATA, 8'h3c);
      bus(1'b1, `SSP_IDX_DATA, 8'h99);
      rdc(`SSP_IDX_STAT, 8'h40);
      for (n = 0; n < 500 && irq !== 1'b1; n++) @(posedge clk);
      chk(32'(irq), 32'h0000_0001);
      chk(32'(ssp_peer_inst.rx_q), 32'h0000_003c);
      rdc(`SSP_IDX_STAT, 8'hc0);
      rdc(`SSP_IDX_DATA, 8'ha5);
      rdc(`SSP_IDX_STAT, 8'h00);
      bus(1'b1, `SSP_IDX_IRQ_MASK, 8'h00);
      @(posedge clk);
      chk(32'(irq), 32'h0000_0000);
      bus(1'b1, `SSP_IDX_IRQ_MASK, 8'h03);
      @(posedge clk);
      chk(32'(irq), 32'h0000_0001);
      bus(1'b1, `SSP_IDX_IRQ_STAT, 8'h03);
      @(posedge clk);
      chk(32'(irq), 32'h0000_0000);
      // disable in mid-byte: the byte never completes
      bus(1'b1, `SSP_IDX_DATA, 8'h0f);
      bus(1'b1, `SSP_IDX_CTRL, 8'h13);
      repeat (100) @(posedge clk);
      rdc(`SSP_IDX_STAT, 8'h00);
      // slave bytes: one whole with done masked, one cut short
      bus(1'b1, `SSP_IDX_IRQ_MASK, 8'h02);
      bus(1'b1, `SSP_IDX_CTRL, 8'h40);
      ssp_peer_inst.send(8'h6b, 8);
      repeat (10) @(posedge clk);
      chk(32'(irq), 32'h0000_0000);
      rdc(`SSP_IDX_STAT, 8'h80);
      rdc(`SSP_IDX_DATA, 8'h6b);
      ssp_peer_inst.send(8'h12, 4);
      repeat (10) @(posedge clk);
      rdc(`SSP_IDX_STAT, 8'h20);
      bus(1'b1, `SSP_IDX_CTRL, 8'h40);
      rdc(`SSP_IDX_STAT, 8'h20);
      bus(1'b1, `SSP_IDX_CTRL, 8'h00);
      rdc(`SSP_IDX_STAT, 8'h00);
      // mode fault as master with select pulled low
      bus(1'b1, `SSP_IDX_IRQ_STAT, 8'h03);
      bus(1'b1, `SSP_IDX_CTRL, 8'h50);
      ssp_peer_inst.sel(1'b0);
      repeat (10) @(posedge clk);
      chk(32'(irq), 32'h0000_0001);
      rdc(`SSP_IDX_STAT, 8'h10);
      ssp_peer_inst.sel(1'b1);
      repeat (10) @(posedge clk);
      bus(1'b1, `SSP_IDX_CTRL, 8'h50);
      rdc(`SSP_IDX_STAT, 8'h00);
      // second reset with a fault standing
      ssp_peer_inst.sel(1'b0);
      repeat (10) @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      ssp_peer_inst.sel(1'b1);
      @(posedge clk);
      rdc(`SSP_IDX_CTRL, 8'h14);
      rdc(`SSP_IDX_STAT, 8'h00);
      end_sim();
   end
endmodule
`default_nettype wire
